// file: srmf_framer.sv
// Serial receive message framer with APB register access and message buffer.
`timescale 1ns/1ps
// Functional notes
// - Idle-line start waits for the configured quiet time in milliseconds.
// - Characters during the idle search are dropped and the idle timer reloads.
// - After idle expiry every following character is stored.
// - Start-character mode ignores characters until the start character, then stores it.
// - Idle plus start character: wrong character restarts the idle search.
// - Break is line low longer than one full character time.
// - Break-only start stores every character after the break.
// - Break plus start character: wrong character restarts the break search.
// - Idle time zero starts storing immediately at launch, unless start-character mode first waits for the start character.
// - Zero idle with message timer starts the timer at launch.
// - End character is compared, stored, and ends the receive.
// - Inter-character timer reloads per character, ends receive on gap overrun.
// - Message timer starts at start condition, ends receive on expiry; a launch straight into storing without idle mode never starts it.
// - Stored count reaching the maximum always ends the receive.
// - A parity error always ends the receive.
// - Launch with enable clear aborts any receive at once.
// - End conditions combine; the first one met ends the receive.
// - Idle start with a nonzero idle time, or break start, aligns to a character boundary before storing.
// - Enable bit is sampled on every launch.
// - Count termination sets its status flag.
// - Parity termination sets its status flag.
module srmf_framer
  import srmf_pkg::*;
#(
  parameter int BUF_DEPTH = 256,
  parameter int TICK_CYCLES = SRMF_TICK_CYC
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_line,
  input wire logic bit_tick,
  input wire srmf_char_s rx_char,
  output logic done
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  initial
  begin
    if (BUF_DEPTH < 256 || TICK_CYCLES < 1)
      $error("srmf_framer: BUF_DEPTH must hold 255 bytes and TICK_CYCLES be positive");
  end

  logic [7:0] ctrl_q, start_ch_q, end_ch_q, max_cnt_q;
  logic [15:0] idle_ms_q, tmo_ms_q, frame_bits_q;
  logic [6:0] status_q, status_d;
  logic [7:0] count_q, count_d, rdptr_q;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [31:0] prdata_q;
  logic [TW-1:0] tick_cnt_q;
  logic ms_tick;
  logic [15:0] idle_cnt_q, idle_cnt_d, tmr_cnt_q, tmr_cnt_d, low_bits_q;
  logic tmr_run_q, tmr_run_d;
  logic brk_seen_q;
  srmf_state_e state_q, state_d;

  // Bus decode; every access completes in its first access cycle.
  wire wr_en = psel && penable && pwrite;
  // Reads are looked up in the setup cycle so that prdata stands through the access cycle.
  wire rd_setup = psel && !penable && !pwrite;
  wire hit_ctrl = paddr == SRMF_CTRL_ADDR;
  wire hit_chars = paddr == SRMF_CHARS_ADDR;
  wire hit_time = paddr == SRMF_TIME_ADDR;
  wire hit_launch = paddr == SRMF_LAUNCH_ADDR;
  wire hit_status = paddr == SRMF_STATUS_ADDR;
  wire hit_count = paddr == SRMF_COUNT_ADDR;
  wire hit_buf = paddr == SRMF_BUF_ADDR;
  wire hit_frame = paddr == SRMF_FRAME_ADDR;
  wire hit_rdptr = paddr == SRMF_RDPTR_ADDR;
  wire hit_any = hit_ctrl | hit_chars | hit_time | hit_launch | hit_status | hit_count
               | hit_buf | hit_frame | hit_rdptr;
  wire launch = wr_en && hit_launch;
  wire ctrl_wr = wr_en && hit_ctrl;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = prdata_q;
  assign done = status_q[SRMF_ST_DONE];

  // Control field selects.
  wire sel_en = ctrl_q[SRMF_EN_BIT];
  wire sel_sc = ctrl_q[SRMF_SC_BIT];
  wire sel_ec = ctrl_q[SRMF_EC_BIT];
  wire sel_il = ctrl_q[SRMF_IL_BIT];
  wire sel_cm = ctrl_q[SRMF_CM_BIT];
  wire sel_tmr = ctrl_q[SRMF_TMR_BIT];
  wire sel_bk = ctrl_q[SRMF_BK_BIT];
  wire launch_en = pwdata[SRMF_EN_BIT];

  // Millisecond tick from the system clock.
  // The tick runs free, so a message or gap timer loaded with N ends N to N+1 milliseconds later, the idle timer N-1 to N.
  wire tick_wrap = tick_cnt_q == TW'(TICK_CYCLES - 1);
  assign ms_tick = tick_wrap;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + TW'(1);
  end

  // Break detector counts bit times with the line low; frame_bits_q is a full character.
  wire brk_now = low_bits_q > frame_bits_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_bits_q <= '0;
      brk_seen_q <= 1'b0;
    end
    else
    begin
      if (rx_line)
        low_bits_q <= '0;
      else if (bit_tick && !brk_now)
        low_bits_q <= low_bits_q + 16'h0001;
      brk_seen_q <= brk_now;
    end
  end
  // Break ends when the line returns high, which is the next character boundary.
  wire brk_end = brk_seen_q && rx_line;

  // Character classification.
  wire ch_in = rx_char.valid;
  wire is_start = rx_char.data == start_ch_q;
  wire is_end = sel_ec && rx_char.data == end_ch_q;
  wire idle_done = idle_cnt_q == 16'h0000;
  wire tmr_exp = tmr_run_q && tmr_cnt_q == 16'h0000 && ms_tick;
  wire wait_start_st = state_q == SRMF_WAIT_START;
  wire take = ch_in && !rx_char.parity_err
              && (state_q == SRMF_STORE || (wait_start_st && is_start));
  wire [7:0] cnt_inc = count_q + 8'h01;

  // Framer sequencing and end conditions; first condition met wins.
  always_comb
  begin
    state_d = state_q;
    status_d = status_q;
    count_d = count_q;
    idle_cnt_d = idle_cnt_q;
    tmr_cnt_d = tmr_cnt_q;
    tmr_run_d = tmr_run_q;
    // A launch restarts the receive and clears the count of an aborted message,
    // so software reads the count before it relaunches.
    if (launch)
    begin
      status_d = '0;
      count_d = '0;
      tmr_run_d = 1'b0;
      idle_cnt_d = idle_ms_q;
      tmr_cnt_d = tmo_ms_q;
      if (!launch_en)
      begin
        state_d = SRMF_OFF;
        if (state_q != SRMF_OFF)
          status_d = 7'(1 << SRMF_ST_USER) | 7'(1 << SRMF_ST_DONE);
      end
      else if (pwdata[SRMF_BK_BIT])
        state_d = SRMF_WAIT_BREAK;
      else if (pwdata[SRMF_IL_BIT])
      begin
        if (idle_ms_q == 16'h0000)
        begin
          state_d = pwdata[SRMF_SC_BIT] ? SRMF_WAIT_START : SRMF_STORE;
          tmr_run_d = pwdata[SRMF_TMR_BIT] && pwdata[SRMF_CM_BIT];
        end
        else
          state_d = SRMF_WAIT_IDLE;
      end
      else if (pwdata[SRMF_SC_BIT])
        state_d = SRMF_WAIT_START;
      else
        state_d = SRMF_STORE;
      if (launch_en)
        status_d[SRMF_ST_ACTIVE] = 1'b1;
    end
    else
    begin
      case (state_q)
        SRMF_OFF: ;
        SRMF_WAIT_IDLE:
        begin
          if (ch_in)
            idle_cnt_d = idle_ms_q;
          else if (ms_tick && !idle_done)
            idle_cnt_d = idle_cnt_q - 16'h0001;
          if (!ch_in && idle_done)
            state_d = SRMF_ALIGN;
        end
        SRMF_WAIT_BREAK:
          if (brk_end)
            state_d = sel_sc ? SRMF_WAIT_START : SRMF_STORE;
        SRMF_ALIGN:
          // Line quiet long enough, so the next start bit is a true boundary.
          if (ch_in)
            idle_cnt_d = idle_ms_q;
          else
            state_d = sel_sc ? SRMF_WAIT_START : SRMF_STORE;
        // A wrong character sends the search back to its own start condition.
        SRMF_WAIT_START:
          if (ch_in && !is_start)
          begin
            idle_cnt_d = idle_ms_q;
            if (sel_bk)
              state_d = SRMF_WAIT_BREAK;
            else if (sel_il && idle_ms_q != 16'h0000)
              state_d = SRMF_WAIT_IDLE;
          end
          else if (ch_in)
            state_d = SRMF_STORE;
        SRMF_STORE: ;
        default: state_d = SRMF_OFF;
      endcase
      // Message timer starts with the start condition.
      if (state_q != SRMF_STORE && state_d == SRMF_STORE && sel_tmr && sel_cm)
      begin
        tmr_run_d = 1'b1;
        tmr_cnt_d = tmo_ms_q;
      end
      // Inter-character timer runs from the first stored character.
      if (take && sel_tmr && !sel_cm)
      begin
        tmr_run_d = 1'b1;
        tmr_cnt_d = tmo_ms_q;
      end
      else if (tmr_run_q && ms_tick && tmr_cnt_q != 16'h0000)
        tmr_cnt_d = tmr_cnt_q - 16'h0001;
      if (take)
        count_d = cnt_inc;
      if (state_q == SRMF_STORE || wait_start_st || state_q == SRMF_WAIT_IDLE
          || state_q == SRMF_WAIT_BREAK || state_q == SRMF_ALIGN)
      begin
        if (ch_in && rx_char.parity_err)
        begin
          state_d = SRMF_OFF;
          status_d[SRMF_ST_PAR] = 1'b1;
        end
        else if (take && is_end)
        begin
          state_d = SRMF_OFF;
          status_d[SRMF_ST_ENDCH] = 1'b1;
        end
        else if (take && cnt_inc >= max_cnt_q)
        begin
          state_d = SRMF_OFF;
          status_d[SRMF_ST_CNT] = 1'b1;
        end
        else if (tmr_exp && sel_tmr)
        begin
          state_d = SRMF_OFF;
          status_d[SRMF_ST_TMR] = 1'b1;
        end
        if (state_d == SRMF_OFF)
        begin
          status_d[SRMF_ST_DONE] = 1'b1;
          status_d[SRMF_ST_ACTIVE] = 1'b0;
          tmr_run_d = 1'b0;
        end
      end
    end
  end

  // Framer state registers.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= SRMF_OFF;
      status_q <= '0;
      count_q <= '0;
      idle_cnt_q <= '0;
      tmr_cnt_q <= '0;
      tmr_run_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      status_q <= status_d;
      count_q <= count_d;
      idle_cnt_q <= idle_cnt_d;
      tmr_cnt_q <= tmr_cnt_d;
      tmr_run_q <= tmr_run_d;
    end
  end

  // Message buffer write; no reset since software reads only counted entries.
  always_ff @(posedge clk)
  begin
    if (take)
      buf_mem[AW'(count_q)] <= rx_char.data;
  end

  // Configuration registers; launch also latches the control byte.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= SRMF_CTRL_RST;
      start_ch_q <= '0;
      end_ch_q <= '0;
      max_cnt_q <= SRMF_MAXCNT_RST;
      idle_ms_q <= '0;
      tmo_ms_q <= '0;
      frame_bits_q <= SRMF_FRAME_RST;
      rdptr_q <= '0;
    end
    else
    begin
      if (ctrl_wr || launch)
        ctrl_q <= pwdata[7:0];
      if (wr_en && hit_chars)
      begin
        start_ch_q <= pwdata[7:0];
        end_ch_q <= pwdata[15:8];
        max_cnt_q <= pwdata[23:16];
      end
      if (wr_en && hit_time)
      begin
        idle_ms_q <= pwdata[15:0];
        tmo_ms_q <= pwdata[31:16];
      end
      if (wr_en && hit_frame)
        frame_bits_q <= pwdata[15:0];
      if (wr_en && hit_rdptr)
        rdptr_q <= pwdata[7:0];
    end
  end

  // Read data mux, loaded at the setup edge so it is valid while pready is high.
  // A status change during the access cycle shows at the next read; this buys zero wait states.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata_q <= '0;
    else if (rd_setup)
    begin
      prdata_q <= '0;
      if (hit_ctrl || hit_launch)
        prdata_q <= {24'h000000, ctrl_q};
      else if (hit_chars)
        prdata_q <= {8'h00, max_cnt_q, end_ch_q, start_ch_q};
      else if (hit_time)
        prdata_q <= {tmo_ms_q, idle_ms_q};
      else if (hit_status)
        prdata_q <= {25'h0000000, status_q};
      else if (hit_count)
        prdata_q <= {24'h000000, count_q};
      else if (hit_buf)
        prdata_q <= {24'h000000, buf_mem[AW'(rdptr_q)]};
      else if (hit_frame)
        prdata_q <= {16'h0000, frame_bits_q};
      else if (hit_rdptr)
        prdata_q <= {24'h000000, rdptr_q};
    end
  end
endmodule

// file: srmf_pkg.sv
// Package for the serial receive message framer: register map, fields, timing.
package srmf_pkg;
  // Register byte addresses on the APB bus.
  localparam logic [7:0] SRMF_CTRL_ADDR = 8'h00;
  localparam logic [7:0] SRMF_CHARS_ADDR = 8'h04;
  localparam logic [7:0] SRMF_TIME_ADDR = 8'h08;
  localparam logic [7:0] SRMF_LAUNCH_ADDR = 8'h0C;
  localparam logic [7:0] SRMF_STATUS_ADDR = 8'h10;
  localparam logic [7:0] SRMF_COUNT_ADDR = 8'h14;
  localparam logic [7:0] SRMF_BUF_ADDR = 8'h18;
  localparam logic [7:0] SRMF_FRAME_ADDR = 8'h1C;
  localparam logic [7:0] SRMF_RDPTR_ADDR = 8'h20;
  // Receive control byte field positions.
  localparam int SRMF_EN_BIT = 7;
  localparam int SRMF_SC_BIT = 6;
  localparam int SRMF_EC_BIT = 5;
  localparam int SRMF_IL_BIT = 4;
  localparam int SRMF_CM_BIT = 3;
  localparam int SRMF_TMR_BIT = 2;
  localparam int SRMF_BK_BIT = 1;
  // Status byte flag positions.
  localparam int SRMF_ST_DONE = 0;
  localparam int SRMF_ST_ENDCH = 1;
  localparam int SRMF_ST_TMR = 2;
  localparam int SRMF_ST_CNT = 3;
  localparam int SRMF_ST_PAR = 4;
  localparam int SRMF_ST_USER = 5;
  localparam int SRMF_ST_ACTIVE = 6;
  // Reset values.
  localparam logic [7:0] SRMF_CTRL_RST = 8'h00;
  localparam logic [7:0] SRMF_MAXCNT_RST = 8'h01;
  localparam logic [15:0] SRMF_FRAME_RST = 16'h000B;
  // Millisecond tick timing.
  localparam int SRMF_CLK_HZ = 100000000;
  localparam int SRMF_TICK_US = 1000;
  localparam int SRMF_TICK_CYC = SRMF_CLK_HZ / 1000000 * SRMF_TICK_US;

  // Received character from the serial receiver.
  typedef struct packed {
    logic valid;
    logic parity_err;
    logic [7:0] data;
  } srmf_char_s;

  // Framer states.
  typedef enum logic [2:0] {
    SRMF_OFF,
    SRMF_WAIT_IDLE,
    SRMF_WAIT_BREAK,
    SRMF_WAIT_START,
    SRMF_ALIGN,
    SRMF_STORE
  } srmf_state_e;
endpackage

// file: srmf_remote.sv
// Remote serial device model: drives the line, the bit clock and character pulses.
`timescale 1ns/1ps
module srmf_remote
  import srmf_pkg::*;
#(
  parameter int BIT_CYC = 4
)(
  input wire logic clk,
  output logic rx_line,
  output logic bit_tick,
  output srmf_char_s rx_char
);
  int div_q = 0;
  // The line idles high and no character is offered at time zero.
  initial
  begin
    rx_line = 1'b1;
    bit_tick = 1'b0;
    rx_char = '0;
  end
  // The bit clock runs free, as the receiver's baud divider does.
  always @(posedge clk)
  begin
    div_q <= (div_q == BIT_CYC - 1) ? 0 : div_q + 1;
    bit_tick <= (div_q == BIT_CYC - 1);
  end
  // Hold the line at one level for a number of bit times.
  task automatic hold(input logic lvl, input int bits);
    rx_line <= lvl;
    repeat (bits * BIT_CYC) @(posedge clk);
  endtask
  // Low for the given bits, then back to idle; more than eleven bits is a break.
  task automatic brk(input int bits);
    hold(1'b0, bits);
    hold(1'b1, 1);
  endtask
  // Eleven-bit character, low data bit first; the receiver pulses at the stop bit.
  task automatic send(input logic [7:0] d, input logic perr = 1'b0);
    int i;
    hold(1'b0, 1);
    for (i = 0; i < 8; i++)
      hold(d[i], 1);
    hold(~^d ^ perr, 1);
    rx_line <= 1'b1;
    rx_char <= {1'b1, perr, d};
    @(posedge clk);
    rx_char <= {2'b00, ~d}; // Stale data is inverted so that nothing can lean on it.
    repeat (BIT_CYC - 1) @(posedge clk);
  endtask
endmodule

// file: srmf_framer_sva.sv
// Assertion checker for the receive message framer, bound to its ports.
`timescale 1ns/1ps
module srmf_framer_chk
  import srmf_pkg::*;
#(
  parameter int TICK_CYCLES = 10
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire srmf_char_s rx_char,
  input wire logic done
);
  logic arm_q, any_q, msg_q, ec_q, done_q;
  logic [7:0] max_q, end_q, cnt_q;
  logic [15:0] idle_q, tmo_q;
  int cyc_q;
  // Decode of launches and of characters seen while a receive runs.
  wire wr = psel && penable && pwrite;
  wire launch = wr && paddr == SRMF_LAUNCH_ADDR;
  wire go = launch && pwdata[SRMF_EN_BIT];
  wire any = (pwdata[7:0] & 8'h52) == 8'h10 && idle_q == 16'h0000;
  wire hit = arm_q && rx_char.valid;
  // Shadow of the settings; every pulse of an armed receive is counted; any_q marks zero-idle idle-line mode with no start character or break.
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      {arm_q, any_q, msg_q, ec_q, done_q, max_q, end_q, cnt_q, idle_q, tmo_q} <= '0;
      cyc_q <= 0;
    end
    else
    begin
      done_q <= done;
      if (wr && paddr == SRMF_CHARS_ADDR) {max_q, end_q} <= pwdata[23:8];
      if (wr && paddr == SRMF_TIME_ADDR) {tmo_q, idle_q} <= pwdata;
      if (launch)
      begin
        {arm_q, any_q, ec_q} <= {go, any, pwdata[SRMF_EC_BIT]};
        msg_q <= any && pwdata[SRMF_CM_BIT] && pwdata[SRMF_TMR_BIT];
        cnt_q <= 8'h00;
        cyc_q <= 0;
      end
      else
      begin
        if (done && !done_q) arm_q <= 1'b0;
        if (hit) cnt_q <= cnt_q + 8'h01;
        if (arm_q) cyc_q <= cyc_q + 1;
      end
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_parity_end: assert property (hit && rx_char.parity_err |-> ##[1:3] done)
    else $error("parity error did not end the receive");
  chk_user_abort: assert property (launch && !pwdata[SRMF_EN_BIT] && arm_q |-> ##[1:3] done)
    else $error("disabled launch did not abort");
  chk_launch_clear: assert property (go |-> ##[1:2] !done)
    else $error("enabled launch left done set");
  chk_count_end: assert property (hit && any_q && cnt_q + 8'h01 >= max_q |-> ##[1:3] done)
    else $error("maximum count did not end the receive");
  chk_end_char: assert property (hit && any_q && ec_q && rx_char.data == end_q |-> ##[1:3] done)
    else $error("end character did not end the receive");
  chk_msg_late: assert property (!(arm_q && msg_q && cyc_q > (tmo_q + 1) * TICK_CYCLES + 2))
    else $error("message timer overran");
  chk_msg_early: assert property (arm_q && msg_q && cnt_q == 8'h00 && !hit
    && cyc_q + TICK_CYCLES < tmo_q * TICK_CYCLES |=> !done)
    else $error("message timer ended early");
  chk_done_holds: assert property (done && !launch |=> done)
    else $error("finished receive did not stay finished");
  cover property (hit && rx_char.parity_err);
  cover property (launch && !pwdata[SRMF_EN_BIT] && arm_q);
  cover property (arm_q && msg_q ##1 done);
endmodule
bind srmf_framer srmf_framer_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .rx_char(rx_char), .done(done));

// file: srmf_framer_tb.sv
// Self-checking testbench for the receive message framer.
`timescale 1ns/1ps
module srmf_framer_tb;
  import srmf_pkg::*;
  logic clk, arst_n, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, done, rx_line, bit_tick, se;
  srmf_char_s rx_char;
  int err_count = 0, num_checks = 0, cyc = 0;
  srmf_remote dev (.clk(clk), .rx_line(rx_line), .bit_tick(bit_tick), .rx_char(rx_char));
  srmf_framer #(.TICK_CYCLES(10)) dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .bit_tick(bit_tick),
    .rx_char(rx_char), .done(done));
  // Clock, and a cycle ceiling that cuts a hung run short.
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; read data and the error flag are taken at the edge that sees pready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    se = pslverr;
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  // Characters word, time word, then the launch with its control byte.
  task automatic run(input logic [31:0] ch, input logic [31:0] tm, input logic [7:0] ctl);
    apb(1'b1, SRMF_CHARS_ADDR, ch);
    apb(1'b1, SRMF_TIME_ADDR, tm);
    apb(1'b1, SRMF_LAUNCH_ADDR, {24'h0, ctl});
  endtask
  // Wait for the end of the receive, then check status and stored count.
  task automatic fin(input logic [6:0] st, input logic [7:0] n);
    int i;
    for (i = 0; i < 3000 && done !== 1'b1; i++)
      @(posedge clk);
    apb(1'b0, SRMF_STATUS_ADDR, 32'h0);
    cmp(rd[6:0], st);
    apb(1'b0, SRMF_COUNT_ADDR, 32'h0);
    cmp(rd[7:0], n);
  endtask
  task automatic chk_b0(input logic [7:0] b0);
    apb(1'b1, SRMF_RDPTR_ADDR, 32'h0);
    apb(1'b0, SRMF_BUF_ADDR, 32'h0);
    cmp(rd[7:0], b0);
  endtask
  task automatic s_regs();
    apb(1'b0, SRMF_CTRL_ADDR, 32'h0);
    cmp(rd[7:0], SRMF_CTRL_RST);
    apb(1'b0, SRMF_FRAME_ADDR, 32'h0);
    cmp(rd[15:0], SRMF_FRAME_RST);
    apb(1'b0, 8'h40, 32'h0);
    cmp(se, 1'b1);
  endtask
  task automatic s_any();
    run(32'h0010_0D00, 32'h0, 8'hB0);
    dev.send(8'h41);
    dev.send(8'h42);
    dev.send(8'h0D);
    fin(7'h03, 8'h03);
    chk_b0(8'h41);
  endtask
  task automatic s_cnt();
    run(32'h0002_0000, 32'h0, 8'h90);
    dev.send(8'h41);
    dev.send(8'h42);
    fin(7'h09, 8'h02);
  endtask
  // Junk before the start character must not reach the buffer.
  task automatic s_start();
    run(32'h0003_003A, 32'h0, 8'hC0);
    dev.send(8'h55);
    dev.send(8'h3A);
    dev.send(8'h31);
    dev.send(8'h32);
    fin(7'h09, 8'h03);
    chk_b0(8'h3A);
  endtask
  task automatic s_par();
    run(32'h0010_0000, 32'h0, 8'h90);
    dev.send(8'h41);
    dev.send(8'h42, 1'b1);
    fin(7'h11, 8'h01);
  endtask
  // Silent line: only the message timer can end it; done must still be low four cycles after launch.
  task automatic s_msg();
    run(32'h0010_0000, 32'h0002_0000, 8'h9C);
    repeat (4) @(posedge clk);
    cmp(done, 1'b0);
    fin(7'h05, 8'h00);
  endtask
  task automatic s_ich();
    run(32'h0010_0000, 32'h000A_0000, 8'h94);
    dev.send(8'h41);
    dev.send(8'h42);
    repeat (50) @(posedge clk);
    cmp(done, 1'b0);
    fin(7'h05, 8'h02);
  endtask
  // The second junk character lands after the first deadline, so only a reload drops it.
  task automatic s_idle();
    run(32'h0010_0D00, 32'h0000_000A, 8'hB0);
    dev.send(8'h55);
    repeat (35) @(posedge clk);
    dev.send(8'h66);
    repeat (120) @(posedge clk);
    dev.send(8'h41);
    dev.send(8'h0D);
    fin(7'h03, 8'h02);
    chk_b0(8'h41);
  endtask
  // A ten-bit low is too short; the fourteen-bit one is a break.
  task automatic s_brk();
    run(32'h0010_0D00, 32'h0, 8'hA2);
    dev.send(8'h55);
    dev.brk(10);
    dev.send(8'h56);
    dev.brk(14);
    dev.send(8'h41);
    dev.send(8'h0D);
    fin(7'h03, 8'h02);
    chk_b0(8'h41);
  endtask
  // Idle plus start character: the wrong character forces a new idle search, so the
  // start character right behind it is dropped and only two characters are stored.
  task automatic s_isc();
    run(32'h0010_313A, 32'h0000_000A, 8'hF0);
    repeat (120) @(posedge clk);
    dev.send(8'h55);
    dev.send(8'h3A);
    repeat (120) @(posedge clk);
    dev.send(8'h3A);
    dev.send(8'h31);
    fin(7'h03, 8'h02);
    chk_b0(8'h3A);
  endtask
  // Break plus start character: the wrong character sends the search back to a break.
  task automatic s_bsc();
    run(32'h0010_313A, 32'h0, 8'hE2);
    dev.brk(14);
    dev.send(8'h55);
    dev.send(8'h3A);
    dev.brk(14);
    dev.send(8'h3A);
    dev.send(8'h31);
    fin(7'h03, 8'h02);
    chk_b0(8'h3A);
  endtask
  task automatic s_abort();
    run(32'h0010_0000, 32'h0, 8'h90);
    dev.send(8'h41);
    apb(1'b1, SRMF_LAUNCH_ADDR, 32'h0);
    fin(7'h21, 8'h00);
  endtask
  // Reset for four cycles, then the scenarios in turn.
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    s_regs();
    s_any();
    s_cnt();
    s_start();
    s_par();
    s_msg();
    s_ich();
    s_idle();
    s_brk();
    s_isc();
    s_bsc();
    s_abort();
    stop_test();
  end
endmodule
